// *** rtl/rct_pkg.sv ***
// Package for the countdown timer block: register map, fields, reset values, rates.
// Assumes a 100 MHz ref_clk and a simple byte-wide register port from the serial front end.
package rct_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    localparam logic [7:0] ADDR_CONTROL_MAIN = 8'h00;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h01;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h02;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h18;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h19;

    localparam int BIT_RUN = 1;
    localparam int BIT_RELOAD = 2;
    localparam int BIT_SEL_LO = 5;
    localparam int BIT_SEL_HI = 6;
    localparam int BIT_TIMER_IRQ = 1;
    localparam int IRQ_IMPL_BITS = 5;

    localparam logic [7:0] CONTROL_MAIN_RESET = 8'h99;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_FLAG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Source tick periods and their length in ref_clk cycles
    localparam int unsigned PERIOD_32HZ_NS = 31_250_000;
    localparam int unsigned PERIOD_8HZ_NS = 125_000_000;
    localparam int unsigned PERIOD_1HZ_NS = 1_000_000_000;
    localparam longint unsigned PERIOD_HALFHZ_NS = 64'd2_000_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CYC_32HZ = PERIOD_32HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_8HZ = PERIOD_8HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_1HZ = PERIOD_1HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_HALFHZ = 32'(PERIOD_HALFHZ_NS / CLK_PERIOD_NS);

    localparam logic [1:0] SEL_32HZ = 2'h0;
    localparam logic [1:0] SEL_8HZ = 2'h1;
    localparam logic [1:0] SEL_1HZ = 2'h2;
    localparam logic [1:0] SEL_HALFHZ = 2'h3;

    typedef enum logic [2:0] {
        CD_IDLE = 3'b001,
        CD_COUNT = 3'b010,
        CD_RELOAD = 3'b100
    } rct_phase_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rct_req_type;

    typedef struct packed {
        logic [7:0] control_main;
        logic [7:0] irq_enable_reg;
        logic [7:0] irq_flag_reg;
        logic [7:0] count_value_low;
        logic [7:0] count_value_high;
        logic [15:0] counter;
        logic [27:0] prescale;
        rct_phase_type phase;
        logic [7:0] rdata;
    } rct_state_type;

endpackage

// *** rtl/rct_timer.sv ***
// Countdown timer with flag and open-drain interrupt, behind a byte register port.
// Assumes the serial bus front end presents one-cycle rd/wr strobes synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Count only while run bit is set
// - Select field picks 32, 8, 1, 0.5 Hz
// - Start value from low and high bytes
// - Zero start value keeps countdown idle with run bit still set
// - Period ends when counter reaches zero
// - Auto-reload restarts the next period
// - Reload costs one extra source tick
// - Enabled end of period sets the flag
// - Interrupt follows flag until host clears it
// - Select and reload writable only when stopped
// - Start bytes writable only when stopped, no reload
// - Upper bits of enable and flag read zero
// - Reset gives stopped timer, 32 Hz, no enables
// - Interrupt is active-low open-drain
module rct_timer #(
    parameter int unsigned PRESCALE_32HZ = rct_pkg::CYC_32HZ,
    parameter int unsigned PRESCALE_8HZ = rct_pkg::CYC_8HZ,
    parameter int unsigned PRESCALE_1HZ = rct_pkg::CYC_1HZ,
    parameter int unsigned PRESCALE_HALFHZ = rct_pkg::CYC_HALFHZ
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire rct_pkg::rct_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic irq_n_in,
    output logic irq_n_out,
    output logic irq_n_oe
);
    import rct_pkg::*;

    // Every divider limit must fit the 28-bit prescale counter
    if (PRESCALE_32HZ < 1 || PRESCALE_8HZ < 1 || PRESCALE_1HZ < 1 || PRESCALE_HALFHZ < 1 ||
        PRESCALE_32HZ > (1 << 28) || PRESCALE_8HZ > (1 << 28) || PRESCALE_1HZ > (1 << 28) ||
        PRESCALE_HALFHZ > (1 << 28)) begin : g_bad_prescale
        $error("rct_timer: prescale out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    rct_state_type state;
    rct_state_type next_state;
    logic [27:0] tick_limit;
    logic tick;
    logic run;
    logic [15:0] start_value;

    assign run = state.control_main[BIT_RUN];
    assign start_value = {state.count_value_high, state.count_value_low};

    always_comb begin
        case ({state.control_main[BIT_SEL_HI], state.control_main[BIT_SEL_LO]})
            SEL_32HZ: tick_limit = 28'(PRESCALE_32HZ - 1);
            SEL_8HZ: tick_limit = 28'(PRESCALE_8HZ - 1);
            SEL_1HZ: tick_limit = 28'(PRESCALE_1HZ - 1);
            default: tick_limit = 28'(PRESCALE_HALFHZ - 1);
        endcase
    end
    assign tick = run && (state.prescale == tick_limit);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic done;
        logic stopped;
        done = 1'b0;
        next_state = state;
        stopped = !run;
        next_state.rdata = 8'h00;

        // Source-clock divider, held in reset while stopped
        if (!run || state.prescale == tick_limit) begin
            next_state.prescale = 28'h0000000;
        end else begin
            next_state.prescale = state.prescale + 28'h0000001;
        end

        case (state.phase)
            CD_IDLE: begin
                next_state.counter = start_value;
                if (run && start_value != 16'h0000) begin
                    next_state.phase = CD_COUNT;
                end
            end
            CD_COUNT: begin
                if (!run) begin
                    next_state.phase = CD_IDLE;
                end else if (tick) begin
                    next_state.counter = state.counter - 16'h0001;
                    if (state.counter == 16'h0001) begin
                        done = 1'b1;
                        next_state.phase = state.control_main[BIT_RELOAD] ? CD_RELOAD : CD_IDLE;
                        if (!state.control_main[BIT_RELOAD]) begin
                            next_state.control_main[BIT_RUN] = 1'b0;
                        end
                    end
                end
            end
            CD_RELOAD: begin
                if (!run) begin
                    next_state.phase = CD_IDLE;
                end else if (tick) begin
                    next_state.counter = start_value;
                    next_state.phase = CD_COUNT;
                end
            end
            default: next_state.phase = CD_IDLE;
        endcase

        // Register writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_CONTROL_MAIN: begin
                    next_state.control_main[7] = reg_req.wdata[7];
                    next_state.control_main[4:3] = reg_req.wdata[4:3];
                    next_state.control_main[0] = reg_req.wdata[0];
                    next_state.control_main[BIT_RUN] = reg_req.wdata[BIT_RUN];
                    if (stopped) begin
                        next_state.control_main[BIT_SEL_HI] = reg_req.wdata[BIT_SEL_HI];
                        next_state.control_main[BIT_SEL_LO] = reg_req.wdata[BIT_SEL_LO];
                        next_state.control_main[BIT_RELOAD] = reg_req.wdata[BIT_RELOAD];
                    end
                end
                ADDR_IRQ_ENABLE: next_state.irq_enable_reg = {3'b000, reg_req.wdata[IRQ_IMPL_BITS-1:0]};
                ADDR_IRQ_FLAG: next_state.irq_flag_reg = {3'b000, state.irq_flag_reg[4:0] & reg_req.wdata[4:0]};
                ADDR_COUNT_LOW: begin
                    if (stopped && !state.control_main[BIT_RELOAD]) begin
                        next_state.count_value_low = reg_req.wdata;
                    end
                end
                ADDR_COUNT_HIGH: begin
                    if (stopped && !state.control_main[BIT_RELOAD]) begin
                        next_state.count_value_high = reg_req.wdata;
                    end
                end
                default: ;
            endcase
        end

        // Flag set wins over a clear in the same cycle
        if (done && state.irq_enable_reg[BIT_TIMER_IRQ]) begin
            next_state.irq_flag_reg[BIT_TIMER_IRQ] = 1'b1;
        end

        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_CONTROL_MAIN: next_state.rdata = state.control_main;
                ADDR_IRQ_ENABLE: next_state.rdata = {3'b000, state.irq_enable_reg[4:0]};
                ADDR_IRQ_FLAG: next_state.rdata = {3'b000, state.irq_flag_reg[4:0]};
                ADDR_COUNT_LOW: next_state.rdata = state.count_value_low;
                ADDR_COUNT_HIGH: next_state.rdata = state.count_value_high;
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state.control_main <= CONTROL_MAIN_RESET;
            state.irq_enable_reg <= IRQ_ENABLE_RESET;
            state.irq_flag_reg <= IRQ_FLAG_RESET;
            state.count_value_low <= COUNT_RESET;
            state.count_value_high <= COUNT_RESET;
            state.counter <= 16'h0000;
            state.prescale <= 28'h0000000;
            state.phase <= CD_IDLE;
            state.rdata <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata = state.rdata;
    assign irq_n_out = 1'b0;
    assign irq_n_oe = !(state.irq_flag_reg[BIT_TIMER_IRQ]);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_last_tick;
        state.phase == CD_COUNT && tick && state.counter == 16'h0001;
    endsequence

    a_flag_on_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_last_tick and state.irq_enable_reg[BIT_TIMER_IRQ] |=> state.irq_flag_reg[BIT_TIMER_IRQ])
        else $error("flag not set at end of period");
    a_irq_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_n_oe == !state.irq_flag_reg[BIT_TIMER_IRQ] && (irq_n_oe || !irq_n_in))
        else $error("interrupt pin does not follow flag");
    a_flag_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state.irq_flag_reg[BIT_TIMER_IRQ] && !(reg_req.wr && reg_req.addr == ADDR_IRQ_FLAG)
        |=> state.irq_flag_reg[BIT_TIMER_IRQ])
        else $error("flag dropped without host clear");
    a_hold_stopped: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !run |=> state.phase == CD_IDLE)
        else $error("countdown active while stopped");
    a_zero_stays: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state.phase == CD_IDLE && start_value == 16'h0000 |=> state.phase != CD_COUNT)
        else $error("zero start value started countdown");
    a_reload_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_last_tick and state.control_main[BIT_RELOAD] |=> state.phase == CD_RELOAD)
        else $error("no reload after period");
    a_reload_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state.phase == CD_RELOAD && tick |=> state.phase == CD_COUNT && state.counter == $past(start_value))
        else $error("reload did not restore start value");
    a_sel_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run |=> $stable(state.control_main[BIT_SEL_HI:BIT_SEL_LO]) && $stable(state.control_main[BIT_RELOAD]))
        else $error("select or reload changed while running");
    a_start_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run || state.control_main[BIT_RELOAD] |=> $stable(start_value))
        else $error("start value changed while locked");
    a_upper_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_req.rd && (reg_req.addr == ADDR_IRQ_FLAG || reg_req.addr == ADDR_IRQ_ENABLE)
        |=> reg_rdata[7:5] == 3'b000)
        else $error("unimplemented bits read nonzero");

endmodule // rct_timer

`default_nettype wire

// *** verif/rct_host_model.sv ***
// Far side of the countdown timer: the pulled-up interrupt wire that the host watches.
// Assumes the design drives low only, with an enable that is low while it drives.
`timescale 1ns/1ns
`default_nettype none
module rct_host_model (
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    output logic irq_line
);
    // Pull-up wins while the pin is released
    assign irq_line = irq_n_oe ? 1'b1 : irq_n_out;
endmodule // rct_host_model
`default_nettype wire

// *** verif/test_rct_timer.sv ***
// Self-checking bench for the countdown timer through its byte register port.
// Assumes short prescale counts in place of the real source clock rates.
`timescale 1ns/1ns
`default_nettype none
module test_rct_timer;
    import rct_pkg::*;
    localparam int unsigned P [4] = '{4, 8, 16, 32};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    rct_req_type reg_req = '0;
    logic [7:0] reg_rdata;
    logic irq_n_out, irq_n_oe, irq_line;
    int n_errors = 0, cmp_count = 0, cyc = 0, t_mark = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    rct_timer #(.PRESCALE_32HZ(P[0]), .PRESCALE_8HZ(P[1]), .PRESCALE_1HZ(P[2]), .PRESCALE_HALFHZ(P[3])) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .irq_n_in(irq_line), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    rct_host_model host (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] cv(input logic [1:0] sel, input logic rel, input logic run);
        return CONTROL_MAIN_RESET | {1'b0, sel, 2'b00, rel, run, 1'b0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        reg_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge ref_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        reg_req = '0;
        chk(reg_rdata, exp, what);
    endtask
    task automatic wait_low(input int exp);
        int k;
        k = 0;
        while (irq_line !== 1'b0 && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        chk(8'(cyc - t_mark), 8'(exp), "period length");
        t_mark = cyc;
    endtask
    task automatic clear_flag();
        wr(ADDR_IRQ_FLAG, 8'hFF);
        chk({7'h00, irq_line}, 8'h00, "flag kept by write one");
        wr(ADDR_IRQ_FLAG, 8'hFD);
        @(negedge ref_clk);
        chk({7'h00, irq_line}, 8'h01, "interrupt released");
        rd(ADDR_IRQ_FLAG, 8'h00, "flag cleared");
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(ADDR_CONTROL_MAIN, CONTROL_MAIN_RESET, "control reset");
        rd(ADDR_IRQ_ENABLE, IRQ_ENABLE_RESET, "enable reset");
        rd(ADDR_IRQ_FLAG, IRQ_FLAG_RESET, "flag reset");
        rd(ADDR_COUNT_HIGH, COUNT_RESET, "count reset");
        rd(8'h05, 8'h00, "unmapped read");
        wr(ADDR_IRQ_ENABLE, 8'hFF);
        rd(ADDR_IRQ_ENABLE, 8'h1F, "enable upper bits");
        wr(ADDR_IRQ_ENABLE, 8'h02);
        wr(ADDR_COUNT_LOW, 8'h02);
        rd(ADDR_COUNT_LOW, 8'h02, "start low byte");
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CONTROL_MAIN, cv(2'(s), 1'b0, 1'b0));
            wr(ADDR_CONTROL_MAIN, cv(2'(s), 1'b0, 1'b1));
            t_mark = cyc;
            wait_low(2 * P[s]);
            chk({7'h00, irq_n_out}, 8'h00, "pin drives low");
            rd(ADDR_IRQ_FLAG, 8'h02, "flag set");
            rd(ADDR_CONTROL_MAIN, cv(2'(s), 1'b0, 1'b0), "one-shot stop");
            clear_flag();
        end
        wr(ADDR_COUNT_HIGH, 8'h01);
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b1));
        wr(ADDR_CONTROL_MAIN, cv(2'h3, 1'b1, 1'b1));
        rd(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b1), "select locked");
        wr(ADDR_COUNT_LOW, 8'h55);
        rd(ADDR_COUNT_LOW, 8'h02, "start locked");
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b0));
        repeat (1100) @(negedge ref_clk);
        chk({7'h00, irq_line}, 8'h01, "stopped timer silent");
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b1, 1'b0));
        rd(ADDR_CONTROL_MAIN, cv(2'h0, 1'b1, 1'b0), "reload set");
        wr(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_COUNT_HIGH, 8'h01, "start locked by reload");
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b0));
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h03);
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b1, 1'b0));
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b1, 1'b1));
        t_mark = cyc;
        wait_low(3 * P[0]);
        clear_flag();
        wait_low(4 * P[0]);
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b0));
        rd(ADDR_CONTROL_MAIN, cv(2'h0, 1'b1, 1'b0), "reload kept while running");
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b0));
        clear_flag();
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b1));
        repeat (100) @(negedge ref_clk);
        rd(ADDR_IRQ_FLAG, 8'h00, "zero start idle");
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b0));
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h01);
        wr(ADDR_CONTROL_MAIN, cv(2'h0, 1'b0, 1'b1));
        repeat (20) @(negedge ref_clk);
        rd(ADDR_IRQ_FLAG, 8'h00, "disabled flag");
        chk({7'h00, irq_line}, 8'h01, "disabled interrupt");
        wr(ADDR_IRQ_ENABLE, 8'h02);
        wr(ADDR_CONTROL_MAIN, cv(2'h2, 1'b1, 1'b0));
        wr(ADDR_CONTROL_MAIN, cv(2'h2, 1'b1, 1'b1));
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(ADDR_CONTROL_MAIN, CONTROL_MAIN_RESET, "control after reset");
        rd(ADDR_IRQ_ENABLE, IRQ_ENABLE_RESET, "enable after reset");
        rd(ADDR_COUNT_LOW, COUNT_RESET, "start after reset");
        tally_and_finish();
    end
endmodule // test_rct_timer
`default_nettype wire
